/* File: include/host_port_pkg.sv */
package host_port_pkg;

   // -----------------------------------------------------------------
   // widths and sizes
   // -----------------------------------------------------------------
   localparam int WORD_W     = 24;
   localparam int BYTE_W     = 8;
   localparam int VEC_W      = 7;
   localparam int FIFO_DEPTH = 16;

   // -----------------------------------------------------------------
   // host-side byte addresses
   // -----------------------------------------------------------------
   localparam logic [2:0] ADDR_ICR     = 3'h0;
   localparam logic [2:0] ADDR_CVR     = 3'h1;
   localparam logic [2:0] ADDR_ISR     = 3'h2;
   localparam logic [2:0] ADDR_BYTE_HI = 3'h5;
   localparam logic [2:0] ADDR_BYTE_MD = 3'h6;
   localparam logic [2:0] ADDR_BYTE_LO = 3'h7;

   // -----------------------------------------------------------------
   // field positions in host-side control bytes
   // -----------------------------------------------------------------
   localparam int CMD_REQ_BIT = 7;
   localparam int FLAG_LSB    = 3;

   // -----------------------------------------------------------------
   // dma request source codes
   // -----------------------------------------------------------------
   localparam logic [4:0] DMA_SRC_RX_FULL  = 5'h13;
   localparam logic [4:0] DMA_SRC_TX_EMPTY = 5'h14;

   // -----------------------------------------------------------------
   // values after reset
   // -----------------------------------------------------------------
   localparam logic RST_EMPTY = 1'b1;
   localparam logic RST_FULL  = 1'b0;

   // host bus strobes, sampled on the core clock
   typedef struct packed {
      logic       cs;
      logic       wr;
      logic       rd;
      logic [2:0] addr;
   } host_bus_s;

   // core control register, bit 4 down to 0
   typedef struct packed {
      logic [1:0] core_to_host_flags;
      logic       command_interrupt_enable;
      logic       tx_interrupt_enable;
      logic       rx_interrupt_enable;
   } core_ctrl_s;

   // core status register, bit 4 down to 0
   typedef struct packed {
      logic [1:0] host_to_core_flags;
      logic       command_pending;
      logic       core_tx_empty_flag;
      logic       core_rx_full_flag;
   } core_stat_s;

endpackage

/* File: src/word_fifo.sv */
`timescale 1ns/1ps
module word_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic             CLK_IN,
   input  wire logic             RST_IN,
   input  wire logic             CE_IN,
   // fill side
   input  wire logic             IN_VALID_IN,
   output logic                  IN_READY_OUT,
   input  wire logic [WIDTH-1:0] IN_DATA_IN,
   // drain side
   output logic                  OUT_VALID_OUT,
   input  wire logic             OUT_READY_IN,
   output logic      [WIDTH-1:0] OUT_DATA_OUT
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
   logic [AW:0]      count_q, count_d;
   logic             push, pop;

   // -----------------------------------------------------------------
   // pointer and count update
   // -----------------------------------------------------------------
   always_comb begin
      push     = IN_VALID_IN && IN_READY_OUT;
      pop      = OUT_VALID_OUT && OUT_READY_IN;
      wr_ptr_d = push ? AW'(wr_ptr_q + 1'b1) : wr_ptr_q;
      rd_ptr_d = pop ? AW'(rd_ptr_q + 1'b1) : rd_ptr_q;
      count_d  = count_q;
      if (push && !pop) begin
         count_d = (AW+1)'(count_q + 1'b1);
      end else if (pop && !push) begin
         count_d = (AW+1)'(count_q - 1'b1);
      end
   end

   // full and empty come straight from the count
   assign IN_READY_OUT  = (count_q != (AW+1)'(DEPTH));
   assign OUT_VALID_OUT = (count_q != '0);
   assign OUT_DATA_OUT  = mem_q[rd_ptr_q];

   // registers; storage array needs no reset
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
      end else if (CE_IN) begin
         wr_ptr_q <= wr_ptr_d;
         rd_ptr_q <= rd_ptr_d;
         count_q  <= count_d;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (CE_IN && push) begin
         mem_q[wr_ptr_q] <= IN_DATA_IN;
      end
   end

endmodule // word_fifo

/* File: src/host_port.sv */
`timescale 1ns/1ps
module host_port (
   // clock, reset, enable
   input  wire logic                      CLK_IN,
   input  wire logic                      RST_IN,
   input  wire logic                      CE_IN,
   // host bus pins
   input  wire host_port_pkg::host_bus_s  HOST_BUS_IN,
   input  wire logic [7:0]                HOST_DATA_IN,
   output logic      [7:0]                HOST_DATA_OUT,
   output logic                           HOST_DATA_OE_OUT,
   // core data words
   input  wire logic                      CORE_TX_WR_IN,
   input  wire logic [23:0]               CORE_TX_DATA_IN,
   input  wire logic                      CORE_RX_RD_IN,
   output logic      [23:0]               CORE_RX_DATA_OUT,
   // core control and status
   input  wire host_port_pkg::core_ctrl_s CORE_CTRL_IN,
   output host_port_pkg::core_stat_s      CORE_STATUS_OUT,
   input  wire logic                      STOP_IN,
   // core interrupts
   output logic                           CORE_IRQ_RX_OUT,
   output logic                           CORE_IRQ_TX_OUT,
   output logic                           CORE_IRQ_CMD_OUT,
   output logic      [7:0]                CORE_IRQ_ADDR_OUT,
   input  wire logic                      CORE_IRQ_ACK_IN,
   // dma request
   input  wire logic [4:0]                DMA_SRC_SEL_IN,
   output logic                           DMA_REQ_OUT
);
   import host_port_pkg::*;

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   logic [7:0]        tx_hi_q, tx_hi_d, tx_md_q, tx_md_d, tx_lo_q, tx_lo_d;
   logic [7:0]        rx_hi_q, rx_hi_d, rx_md_q, rx_md_d, rx_lo_q, rx_lo_d;
   logic              host_tx_empty_q, host_tx_empty_d;
   logic              host_rx_full_q, host_rx_full_d;
   logic [WORD_W-1:0] core_tx_word_q, core_tx_word_d;
   logic [WORD_W-1:0] core_rx_word_q, core_rx_word_d;
   logic              core_tx_empty_q, core_tx_empty_d;
   logic              core_rx_full_q, core_rx_full_d;
   logic [1:0]        icr_flags_q, icr_flags_d;
   logic [1:0]        c2h_s1_q, c2h_s2_q, h2c_s1_q, h2c_s2_q;
   logic              cmd_pend_q, cmd_pend_d;
   logic [VEC_W-1:0]  cmd_vec_q, cmd_vec_d;
   logic [7:0]        rdata_q, rdata_d;
   logic              oe_q, oe_d;

   // -----------------------------------------------------------------
   // strobes and fifo hookup
   // -----------------------------------------------------------------
   logic              host_ok, hwr, hrd, push, pop, to_host;
   logic              fifo_in_ready, fifo_out_valid;
   logic [WORD_W-1:0] fifo_out_data;

   function automatic logic hit(input logic [2:0] a, input logic [2:0] off);
      return a == off;
   endfunction

   // pins are ignored entirely while the core is stopped
   assign host_ok = HOST_BUS_IN.cs && !STOP_IN;
   assign hwr     = host_ok && HOST_BUS_IN.wr;
   assign hrd     = host_ok && HOST_BUS_IN.rd;
   assign push    = !host_tx_empty_q && fifo_in_ready;
   assign pop     = fifo_out_valid && !core_rx_full_q;
   assign to_host = !core_tx_empty_q && !host_rx_full_q;

   // the fifo absorbs bursts so the two sides keep their own pace
   word_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) word_fifo_i (
      .CLK_IN        (CLK_IN),
      .RST_IN        (RST_IN),
      .CE_IN         (CE_IN),
      .IN_VALID_IN   (!host_tx_empty_q),
      .IN_READY_OUT  (fifo_in_ready),
      .IN_DATA_IN    ({tx_hi_q, tx_md_q, tx_lo_q}),
      .OUT_VALID_OUT (fifo_out_valid),
      .OUT_READY_IN  (!core_rx_full_q),
      .OUT_DATA_OUT  (fifo_out_data)
   );

   // -----------------------------------------------------------------
   // host side: byte registers, control, read mux
   // -----------------------------------------------------------------
   always_comb begin
      tx_hi_d         = tx_hi_q;
      tx_md_d         = tx_md_q;
      tx_lo_d         = tx_lo_q;
      host_tx_empty_d = host_tx_empty_q;
      icr_flags_d     = icr_flags_q;
      cmd_pend_d      = cmd_pend_q;
      cmd_vec_d       = cmd_vec_q;
      rdata_d         = rdata_q;
      oe_d            = hrd;
      // push frees the byte registers for the next word
      if (push) begin
         host_tx_empty_d = 1'b1;
      end
      if (hwr) begin
         if (hit(HOST_BUS_IN.addr, ADDR_BYTE_HI)) begin
            tx_hi_d = HOST_DATA_IN;
         end
         if (hit(HOST_BUS_IN.addr, ADDR_BYTE_MD)) begin
            tx_md_d = HOST_DATA_IN;
         end
         // low byte completes the word; set wins over push
         if (hit(HOST_BUS_IN.addr, ADDR_BYTE_LO)) begin
            tx_lo_d         = HOST_DATA_IN;
            host_tx_empty_d = 1'b0;
         end
         if (hit(HOST_BUS_IN.addr, ADDR_ICR)) begin
            icr_flags_d = HOST_DATA_IN[FLAG_LSB +: 2];
         end
      end
      // acknowledge ends the command; a new request in that cycle wins
      if (CORE_IRQ_ACK_IN) begin
         cmd_pend_d = 1'b0;
      end
      if (hwr && hit(HOST_BUS_IN.addr, ADDR_CVR) &&
          HOST_DATA_IN[CMD_REQ_BIT] && (!cmd_pend_q || CORE_IRQ_ACK_IN)) begin
         cmd_pend_d = 1'b1;
         cmd_vec_d  = HOST_DATA_IN[VEC_W-1:0];
      end
      if (hrd) begin
         case (HOST_BUS_IN.addr)
            ADDR_ICR:     rdata_d = {3'h0, icr_flags_q, 3'h0};
            ADDR_CVR:     rdata_d = {cmd_pend_q, cmd_vec_q};
            ADDR_ISR:     rdata_d = {3'h0, c2h_s2_q, 1'b0,
                                     host_tx_empty_q, host_rx_full_q};
            ADDR_BYTE_HI: rdata_d = rx_hi_q;
            ADDR_BYTE_MD: rdata_d = rx_md_q;
            ADDR_BYTE_LO: rdata_d = rx_lo_q;
            default:      rdata_d = 8'h00;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // core side data path and the move toward the host
   // -----------------------------------------------------------------
   always_comb begin
      core_tx_word_d  = core_tx_word_q;
      core_tx_empty_d = core_tx_empty_q;
      core_rx_word_d  = core_rx_word_q;
      core_rx_full_d  = core_rx_full_q;
      rx_hi_d         = rx_hi_q;
      rx_md_d         = rx_md_q;
      rx_lo_d         = rx_lo_q;
      host_rx_full_d  = host_rx_full_q;
      // host reading the low byte frees the receive bytes
      if (hrd && hit(HOST_BUS_IN.addr, ADDR_BYTE_LO)) begin
         host_rx_full_d = 1'b0;
      end
      if (to_host) begin
         {rx_hi_d, rx_md_d, rx_lo_d} = core_tx_word_q;
         host_rx_full_d  = 1'b1;
         core_tx_empty_d = 1'b1;
      end
      // core write after the move keeps the new word pending
      if (CORE_TX_WR_IN) begin
         core_tx_word_d  = CORE_TX_DATA_IN;
         core_tx_empty_d = 1'b0;
      end
      if (CORE_RX_RD_IN) begin
         core_rx_full_d = 1'b0;
      end
      // pop only when empty, so it never meets a read-clear
      if (pop) begin
         core_rx_word_d = fifo_out_data;
         core_rx_full_d = 1'b1;
      end
   end

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         tx_hi_q         <= 8'h00;
         tx_md_q         <= 8'h00;
         tx_lo_q         <= 8'h00;
         rx_hi_q         <= 8'h00;
         rx_md_q         <= 8'h00;
         rx_lo_q         <= 8'h00;
         host_tx_empty_q <= RST_EMPTY;
         host_rx_full_q  <= RST_FULL;
         core_tx_word_q  <= 24'h000000;
         core_rx_word_q  <= 24'h000000;
         core_tx_empty_q <= RST_EMPTY;
         core_rx_full_q  <= RST_FULL;
         icr_flags_q     <= 2'h0;
         c2h_s1_q        <= 2'h0;
         c2h_s2_q        <= 2'h0;
         h2c_s1_q        <= 2'h0;
         h2c_s2_q        <= 2'h0;
         cmd_pend_q      <= 1'b0;
         cmd_vec_q       <= 7'h00;
         rdata_q         <= 8'h00;
         oe_q            <= 1'b0;
      end else if (CE_IN) begin
         tx_hi_q         <= tx_hi_d;
         tx_md_q         <= tx_md_d;
         tx_lo_q         <= tx_lo_d;
         rx_hi_q         <= rx_hi_d;
         rx_md_q         <= rx_md_d;
         rx_lo_q         <= rx_lo_d;
         host_tx_empty_q <= host_tx_empty_d;
         host_rx_full_q  <= host_rx_full_d;
         core_tx_word_q  <= core_tx_word_d;
         core_rx_word_q  <= core_rx_word_d;
         core_tx_empty_q <= core_tx_empty_d;
         core_rx_full_q  <= core_rx_full_d;
         icr_flags_q     <= icr_flags_d;
         // two-stage flag mirrors; first stage feeds only the second
         c2h_s1_q        <= CORE_CTRL_IN.core_to_host_flags;
         c2h_s2_q        <= c2h_s1_q;
         h2c_s1_q        <= icr_flags_q;
         h2c_s2_q        <= h2c_s1_q;
         cmd_pend_q      <= cmd_pend_d;
         cmd_vec_q       <= cmd_vec_d;
         rdata_q         <= rdata_d;
         oe_q            <= oe_d && !STOP_IN;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign HOST_DATA_OUT    = rdata_q;
   assign HOST_DATA_OE_OUT = oe_q && !STOP_IN;
   assign CORE_RX_DATA_OUT = core_rx_word_q;
   assign CORE_STATUS_OUT  = '{host_to_core_flags: h2c_s2_q,
                               command_pending:    cmd_pend_q,
                               core_tx_empty_flag: core_tx_empty_q,
                               core_rx_full_flag:  core_rx_full_q};
   assign CORE_IRQ_RX_OUT  = core_rx_full_q &&
                             CORE_CTRL_IN.rx_interrupt_enable;
   assign CORE_IRQ_TX_OUT  = core_tx_empty_q &&
                             CORE_CTRL_IN.tx_interrupt_enable;
   assign CORE_IRQ_CMD_OUT = cmd_pend_q &&
                             CORE_CTRL_IN.command_interrupt_enable;
   assign CORE_IRQ_ADDR_OUT = {cmd_vec_q, 1'b0};
   // dma sees only core-side flags, never host bytes
   assign DMA_REQ_OUT =
      (DMA_SRC_SEL_IN == DMA_SRC_RX_FULL && core_rx_full_q) ||
      (DMA_SRC_SEL_IN == DMA_SRC_TX_EMPTY && core_tx_empty_q);

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   property p_pop_fills;
      @(posedge CLK_IN) disable iff (RST_IN || !CE_IN)
      pop |=> core_rx_full_q && core_rx_word_q == $past(fifo_out_data);
   endproperty
   a_pop_fills: assert property (p_pop_fills)
      else $error("word popped but core receive not full");

   property p_move_to_host;
      @(posedge CLK_IN) disable iff (RST_IN || !CE_IN)
      to_host && !CORE_TX_WR_IN |=> host_rx_full_q && core_tx_empty_q;
   endproperty
   a_move_to_host: assert property (p_move_to_host)
      else $error("core word not moved to host bytes");

   property p_no_move_when_full;
      @(posedge CLK_IN) disable iff (RST_IN || !CE_IN)
      host_rx_full_q && !hrd |=> $stable({rx_hi_q, rx_md_q, rx_lo_q});
   endproperty
   a_no_move_when_full: assert property (p_no_move_when_full)
      else $error("host receive bytes overwritten while full");

   property p_rx_read_clears;
      @(posedge CLK_IN) disable iff (RST_IN || !CE_IN)
      CORE_RX_RD_IN && core_rx_full_q |=> !core_rx_full_q;
   endproperty
   a_rx_read_clears: assert property (p_rx_read_clears)
      else $error("core read did not clear receive full");

   property p_cmd_ack;
      @(posedge CLK_IN) disable iff (RST_IN || !CE_IN)
      // a fresh host request right after the acknowledge may set it again
      cmd_pend_q && CORE_IRQ_ACK_IN && !hwr |=> !cmd_pend_q ##1
         (!cmd_pend_q || $past(hwr));
   endproperty
   a_cmd_ack: assert property (p_cmd_ack)
      else $error("acknowledge did not clear command pending");

   property p_cmd_addr;
      @(posedge CLK_IN) disable iff (RST_IN || !CE_IN)
      hwr && hit(HOST_BUS_IN.addr, ADDR_CVR) && HOST_DATA_IN[CMD_REQ_BIT]
         && !cmd_pend_q |=>
         CORE_IRQ_ADDR_OUT == 8'($past(HOST_DATA_IN) & 8'h7F) * 8'h02;
   endproperty
   a_cmd_addr: assert property (p_cmd_addr)
      else $error("command interrupt address not twice vector");

   property p_stop_quiet;
      @(posedge CLK_IN) disable iff (RST_IN || !CE_IN)
      // internal moves may go on; host writes must not land
      STOP_IN |-> !HOST_DATA_OE_OUT ##1
         (!STOP_IN || $stable({tx_hi_q, tx_md_q, tx_lo_q, icr_flags_q}));
   endproperty
   a_stop_quiet: assert property (p_stop_quiet)
      else $error("port active during stop");

   property p_flag_mirror;
      @(posedge CLK_IN) disable iff (RST_IN || !CE_IN)
      CE_IN [*3] |-> c2h_s2_q == $past(CORE_CTRL_IN.core_to_host_flags, 2);
   endproperty
   a_flag_mirror: assert property (p_flag_mirror)
      else $error("core flags not mirrored after two cycles");

   property p_dma_rx;
      @(posedge CLK_IN) disable iff (RST_IN || !CE_IN)
      DMA_SRC_SEL_IN == DMA_SRC_RX_FULL |-> DMA_REQ_OUT == core_rx_full_q;
   endproperty
   a_dma_rx: assert property (p_dma_rx)
      else $error("dma request does not follow receive full");

   property p_irq_tx;
      @(posedge CLK_IN) disable iff (RST_IN || !CE_IN)
      CORE_TX_WR_IN |=> !CORE_IRQ_TX_OUT;
   endproperty
   a_irq_tx: assert property (p_irq_tx)
      else $error("tx interrupt still raised after core write");

   c_word_in:  cover property (@(posedge CLK_IN) pop ##[1:20] CORE_RX_RD_IN);
   c_word_out: cover property (@(posedge CLK_IN) to_host ##[1:20]
                               (hrd && hit(HOST_BUS_IN.addr, ADDR_BYTE_LO)));
   c_fifo_full: cover property (@(posedge CLK_IN) !fifo_in_ready);
   c_command:  cover property (@(posedge CLK_IN) CORE_IRQ_CMD_OUT ##1
                               CORE_IRQ_ACK_IN);

endmodule // host_port

/* File: tb/host_model.sv */
`timescale 1ns/1ps
// ----
// host processor model, masters every bus cycle
// ----
module host_model (
   // clock
   input  wire logic                     clk_in,
   // byte bus toward the port
   output host_port_pkg::host_bus_s      bus_out,
   output logic [7:0]                    data_out,
   input  wire logic [7:0]               data_in
);
   import host_port_pkg::*;
   // deselected at time zero
   initial begin
      bus_out  = '0;
      data_out = 8'h00;
   end
   // one write cycle, held to the sampling edge
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      bus_out  = '{cs: 1'b1, wr: 1'b1, rd: 1'b0, addr: a};
      data_out = d;
      @(posedge clk_in);
      #1;
   endtask
   // one read cycle, data taken one cycle on
   task automatic rd(input logic [2:0] a, output logic [7:0] q);
      bus_out = '{cs: 1'b1, wr: 1'b0, rd: 1'b1, addr: a};
      @(posedge clk_in);
      #1;
      q = data_in;
   endtask
   // release: inverse data so a stale byte never passes for a match
   task automatic idle();
      bus_out  = '0;
      data_out = ~data_out;
      @(posedge clk_in);
      #1;
   endtask
endmodule // host_model

/* File: tb/host_port_tb.sv */
`timescale 1ns/1ps
module host_port_tb;
   import host_port_pkg::*;
   // ----
   // stimulus and observed signals
   // ----
   logic        clk = 1'b0, rst = 1'b1, stop = 1'b0;
   logic        txw = 1'b0, rxr = 1'b0, ack = 1'b0;
   logic [23:0] txd = '0, rxd, w, v, lf = 24'h000040;
   logic [4:0]  sel = DMA_SRC_RX_FULL;
   core_ctrl_s  ctrl = 5'b00011;
   core_stat_s  st;
   host_bus_s   bus;
   logic [7:0]  hdi, hdo, q, iaddr;
   logic [6:0]  hv;
   logic        oe, irx, itx, icmd, dreq, rxf_q = 1'b0;
   int          error_cnt = 0, check_count = 0, n;
   logic [7:0]  hq[$];
   logic [23:0] cq[$];

   always #10 clk = ~clk;

   host_model host_model_i (.clk_in(clk), .bus_out(bus), .data_out(hdi),
      .data_in(hdo));
   host_port host_port_i (.CLK_IN(clk), .RST_IN(rst), .CE_IN(1'b1),
      .HOST_BUS_IN(bus), .HOST_DATA_IN(hdi), .HOST_DATA_OUT(hdo),
      .HOST_DATA_OE_OUT(oe), .CORE_TX_WR_IN(txw), .CORE_TX_DATA_IN(txd),
      .CORE_RX_RD_IN(rxr), .CORE_RX_DATA_OUT(rxd), .CORE_CTRL_IN(ctrl),
      .CORE_STATUS_OUT(st), .STOP_IN(stop), .CORE_IRQ_RX_OUT(irx),
      .CORE_IRQ_TX_OUT(itx), .CORE_IRQ_CMD_OUT(icmd),
      .CORE_IRQ_ADDR_OUT(iaddr), .CORE_IRQ_ACK_IN(ack),
      .DMA_SRC_SEL_IN(sel), .DMA_REQ_OUT(dreq));

   // ----
   // helpers
   // ----
   // 24-bit lfsr, fixed start so runs repeat
   function automatic logic [23:0] rnd();
      lf = {lf[22:0], lf[23] ^ lf[22] ^ lf[21] ^ lf[16]};
      return lf;
   endfunction
   task automatic chk(input string s, input logic [23:0] seen, e);
      check_count++;
      if (seen !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", s, e, seen);
      end
   endtask
   task automatic complete_run();
      chk("queues", 24'(hq.size() + cq.size()), 24'h0);
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   // poll one isr bit, bounded so a stuck flag ends the run
   task automatic pol(input int b, input logic x);
      for (n = 0; n < 60; n++) begin
         host_model_i.rd(ADDR_ISR, q);
         if (q[b] === x) break;
      end
      host_model_i.idle();
      if (n == 60) begin
         chk("poll", 24'h1, 24'h0);
         complete_run();
      end
   endtask
   task automatic hword(input logic [23:0] d);
      pol(1, 1'b1);
      host_model_i.wr(ADDR_BYTE_HI, d[23:16]);
      host_model_i.wr(ADDR_BYTE_MD, d[15:8]);
      host_model_i.wr(ADDR_BYTE_LO, d[7:0]);
      cq.push_back(d);
      host_model_i.idle();
   endtask
   task automatic hrw(input logic [23:0] d);
      pol(0, 1'b1);
      hq.push_back(d[23:16]);
      host_model_i.rd(ADDR_BYTE_HI, q);
      hq.push_back(d[15:8]);
      host_model_i.rd(ADDR_BYTE_MD, q);
      hq.push_back(d[7:0]);
      host_model_i.rd(ADDR_BYTE_LO, q);
      host_model_i.idle();
   endtask
   task automatic crd();
      for (n = 0; n < 30 && st.core_rx_full_flag !== 1'b1; n++) cyc(1);
      if (n == 30) begin
         chk("rx wait", 24'h1, 24'h0);
         complete_run();
      end
      rxr = 1'b1;
      cyc(1);
      rxr = 1'b0;
      chk("rx clear", 24'({st.core_rx_full_flag, irx}), 24'h0);
   endtask

   // results are judged as they appear, oldest note first
   always @(posedge clk) begin
      if (oe === 1'b1 && hq.size() > 0) begin
         chk("host byte", 24'(hdo), 24'(hq.pop_front()));
      end
      if (st.core_rx_full_flag === 1'b1 && rxf_q !== 1'b1) begin
         chk("core word", rxd, cq.pop_front());
      end
      rxf_q <= st.core_rx_full_flag;
   end

   initial begin
      cyc(20);
      rst = 1'b0;
      chk("status", 24'(st), 24'h02);
      chk("irq tx", 24'(itx), 24'h1);
      host_model_i.rd(ADDR_ISR, q);
      host_model_i.idle();
      chk("isr", 24'(q), 24'h02);
      $display("test reset done");
      // fill core word, fifo and host bytes until the host side stalls
      for (int i = 0; i < 18; i++) hword(rnd());
      cyc(20);
      host_model_i.rd(ADDR_ISR, q);
      host_model_i.idle();
      chk("stall", 24'(q[1]), 24'h0);
      chk("irq dma", 24'({irx, dreq}), 24'h3);
      for (int i = 0; i < 18; i++) crd();
      cyc(3);
      chk("drained", 24'({irx, dreq}), 24'h0);
      $display("test fill_drain done");
      // core to host, second word waits for the host read
      w = rnd();
      v = rnd();
      txd = w;
      txw = 1'b1;
      cyc(1);
      txd = v;
      cyc(1);
      txw = 1'b0;
      cyc(3);
      chk("tx held", 24'({st.core_tx_empty_flag, itx}), 24'h0);
      hrw(w);
      hrw(v);
      cyc(3);
      chk("tx free", 24'({st.core_tx_empty_flag, itx}), 24'h3);
      $display("test core_to_host done");
      // flags both ways
      ctrl.core_to_host_flags = 2'b10;
      host_model_i.wr(ADDR_ICR, 8'h08);
      host_model_i.idle();
      cyc(4);
      chk("core flags", 24'(st.host_to_core_flags), 24'h1);
      hq.push_back(8'h08);
      host_model_i.rd(ADDR_ICR, q);
      host_model_i.rd(ADDR_ISR, q);
      host_model_i.idle();
      chk("isr flags", 24'(q), 24'h12);
      $display("test flags done");
      // host commands, vector bounds and a random one
      ctrl.command_interrupt_enable = 1'b1;
      for (int i = 0; i < 3; i++) begin
         v = rnd();
         hv = (i == 0) ? 7'h00 : (i == 1) ? 7'h7F : v[6:0];
         host_model_i.wr(ADDR_CVR, {1'b1, hv});
         host_model_i.idle();
         cyc(1);
         chk("cmd", {14'h0, icmd, st.command_pending, hv, 1'b0},
            {14'h0, 2'b11, iaddr});
         rxr = 1'b1;
         cyc(1);
         rxr = 1'b0;
         cyc(1);
         chk("cmd kept", 24'(st.command_pending), 24'h1);
         ack = 1'b1;
         cyc(1);
         ack = 1'b0;
         cyc(1);
         chk("cmd ack", 24'({icmd, st.command_pending}), 24'h0);
      end
      $display("test command done");
      // dma source codes at idle: receive empty, transmit empty
      for (int i = 0; i < 3; i++) begin
         sel = (i == 0) ? 5'h13 : (i == 1) ? 5'h14 : 5'h00;
         cyc(1);
         chk("dma", 24'(dreq), 24'(i == 1));
      end
      $display("test dma done");
      // stop mode: strobes ignored, no drive
      stop = 1'b1;
      host_model_i.wr(ADDR_BYTE_HI, 8'hA5);
      host_model_i.wr(ADDR_BYTE_LO, 8'h5A);
      host_model_i.rd(ADDR_ISR, q);
      chk("stop oe", 24'(oe), 24'h0);
      host_model_i.idle();
      cyc(5);
      stop = 1'b0;
      chk("stop rx", 24'(st.core_rx_full_flag), 24'h0);
      host_model_i.rd(ADDR_ISR, q);
      host_model_i.idle();
      chk("stop isr", 24'(q[1:0]), 24'h2);
      $display("test stop done");
      complete_run();
   end
endmodule // host_port_tb
